// file: sim/sicr_host.sv
// SPI master model clocking data-only reads out of the block
module sicr_host (
  input wire logic sdo_o,
  input wire logic sdo_oe_n,
  output logic sclk,
  output logic cs_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last_bit;
  logic [7:0] sh;
  logic [7:0] got [$];
  int bad;
  wire logic sdo_line;
  // Released line shows the inverse of the last driven bit
  assign sdo_line = sdo_oe_n ? ~last_bit : sdo_o;
  always @(sdo_o or sdo_oe_n) begin
    if (!sdo_oe_n) begin
      last_bit = sdo_o;
    end
  end
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    last_bit = 1'b0;
  end
  // One frame of nb bytes; hold says where sdo must let go
  task automatic frame(input int nb, input logic hold);
    got.delete();
    bad = 0;
    #1.3;
    cs_n = 1'b0;
    #200;
    for (int i = 1; i <= nb * 8; i++) begin
      #32 sclk = 1'b1;
      sh = {sh[6:0], sdo_line};
      if (i % 8 == 0) begin
        got.push_back(sh);
      end
      if (i == nb * 8) begin
        #20 bad += int'(sdo_oe_n !== ~hold);
        #12 sclk = 1'b0;
        #20 bad += int'(sdo_oe_n !== 1'b1);
        #12;
      end else begin
        #32 sclk = 1'b0;
      end
    end
    cs_n = 1'b1;
    #40;
  endtask
endmodule

// file: sim/sicr_regs_sva.sv
// Port-level checks for the serial interface control registers
module sicr_regs_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic cs_n,
  input wire logic sdo_oe_n,
  input wire logic conversion_done,
  input wire logic conversion_ready_n,
  input wire logic check_clear,
  input wire logic gpio_pin_six_o,
  input wire logic gpio_pin_six_oe_n_o,
  input wire sicr_pkg::sicr_cfg_s cfg
);
  // ------------------------------------------------------------
  // Write decode, aligned words in the low index space only
  // ------------------------------------------------------------
  wire logic [7:0] idx;
  wire logic wr;
  assign idx = paddr[9:2];
  assign wr = psel && penable && pwrite && paddr[1:0] == 2'h0 &&
              paddr[31:10] == 22'h0;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  kind_write_a: assert property (
    wr && idx == sicr_pkg::IDX_STREAM
    |=> cfg.stream_kind_sel == $past(pwdata[7]))
    else $error("stream kind not stored");
  range_write_a: assert property (
    wr && idx == sicr_pkg::IDX_STREAM
    |=> cfg.controlled_stream_len == $past(pwdata[6:0]))
    else $error("stream range not stored");
  start_write_a: assert property (
    wr && idx == sicr_pkg::IDX_RD_START
    |=> cfg.direct_read_start == $past(pwdata[6:0]))
    else $error("read start not stored");
  count_write_a: assert property (
    wr && idx == sicr_pkg::IDX_RD_LEN
    |=> cfg.direct_read_byte_count == $past(pwdata[2:0]))
    else $error("read count not stored");
  gain_write_a: assert property (
    wr && idx == sicr_pkg::IDX_READY_CTL
    |=> cfg.fixed_gain_cal_sel == $past(pwdata[3]))
    else $error("gain select not stored");
  // Routing may take a cycle, so only settled states are judged
  pin_route_a: assert property (
    cfg.ready_on_pin_six && $past(cfg.ready_on_pin_six)
    && $stable(conversion_ready_n)
    |-> !gpio_pin_six_oe_n_o && gpio_pin_six_o == conversion_ready_n)
    else $error("ready not on pin six");
  clear_on_rise_a: assert property (
    $rose(conversion_ready_n) && !cfg.check_reset_disable
    |-> ##[0:2] check_clear)
    else $error("check clear missing");
  no_clear_a: assert property (
    cfg.check_reset_disable && $past(cfg.check_reset_disable)
    && $past(cfg.check_reset_disable, 2) |-> !check_clear)
    else $error("check clear while disabled");
  ready_set_a: assert property (
    conversion_done |=> !conversion_ready_n)
    else $error("ready not asserted");
  idle_release_a: assert property (
    cs_n [*6] |-> sdo_oe_n)
    else $error("sdo driven while deselected");
endmodule

// file: sim/tb.sv
// Self-checking bench for the serial interface control registers
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [31:0] paddr, pwdata, prdata, q;
  logic sclk, cs_n, sdo_o, sdo_oe_n, conversion_done, conversion_ready_n;
  logic check_clear, gp_out, gp_oe_n, gpio_pin_six_o, gpio_pin_six_oe_n_o;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  logic [15:0] seed;
  sicr_pkg::sicr_cfg_s cfg;
  int n_mismatch, checked, n_clr, cycles;
  // Register model: index, writable bits, reset value, contents
  logic [7:0] idxs [7] = '{8'h01, 8'h03, 8'h09, 8'h0A, 8'h11, 8'h20, 8'h21};
  logic [7:0] wmask [7] = '{8'h01, 8'hFF, 8'h7F, 8'h07, 8'hAF, 8'h03, 8'h03};
  logic [7:0] rst [7] = '{8'h00, 8'h00, 8'h1A, 8'h02, 8'h03, 8'h00, 8'h00};
  logic [7:0] mdl [7];
  // Register space seen by the read engine
  assign rd_data = {rd_addr, 1'b1} ^ 8'h3C;
  sicr_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk),
    .cs_n(cs_n), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .rd_addr(rd_addr),
    .rd_data(rd_data), .conversion_done(conversion_done),
    .conversion_ready_n(conversion_ready_n), .check_clear(check_clear),
    .gpio_pin_six_out(gp_out), .gpio_pin_six_oe_n(gp_oe_n),
    .gpio_pin_six_o(gpio_pin_six_o),
    .gpio_pin_six_oe_n_o(gpio_pin_six_oe_n_o), .cfg(cfg), .irq(irq));
  sicr_host host (.sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .sclk(sclk),
    .cs_n(cs_n));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Hang guard, well above the longest frame sequence
  always @(posedge pclk) begin
    cycles++;
    if (check_clear === 1'b1) n_clr++;
    if (cycles == 80000) begin
      n_mismatch++;
      conclude();
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] pat(input logic [7:0] a);
    return {a[6:0], 1'b1} ^ 8'h3C;
  endfunction
  task automatic conclude();
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One APB transfer; waits for pready, samples at that edge
  task automatic apb(input logic w, input logic [7:0] i,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Status is write-one-to-clear, the rest plain storage
  task automatic wr(input int k, input logic [7:0] d);
    apb(1'b1, idxs[k], {24'h0, d});
    mdl[k] = (k == 5) ? mdl[5] & ~d : d & wmask[k];
  endtask
  task automatic rd(input int k);
    apb(1'b0, idxs[k], 32'h0);
    `CHK(q, {24'h0, mdl[k]})
    `CHK(e, 1'b0)
  endtask
  task automatic chk_cfg();
    `CHK(cfg.output_release_delay_sel, mdl[0][0])
    `CHK(cfg.stream_kind_sel, mdl[1][7])
    `CHK(cfg.controlled_stream_len, mdl[1][6:0])
    `CHK(cfg.direct_read_start, mdl[2][6:0])
    `CHK(cfg.direct_read_byte_count, mdl[3][2:0])
    `CHK(cfg.ready_on_pin_six, mdl[4][7])
    `CHK(cfg.check_reset_disable, mdl[4][5])
    `CHK(cfg.fixed_gain_cal_sel, mdl[4][3])
  endtask
  task automatic frame_chk(input int nb);
    host.frame(nb, mdl[0][0]);
    repeat (8) @(posedge pclk);
    mdl[5] = mdl[5] | 8'h01;
    `CHK(host.got.size(), nb)
    foreach (host.got[j]) `CHK(host.got[j], pat(mdl[2] + j))
    `CHK(host.bad, 0)
    rd(5);
    `CHK(irq, |(mdl[5] & mdl[6]))
  endtask
  task automatic pulse();
    @(posedge pclk);
    conversion_done <= 1'b1;
    @(posedge pclk);
    conversion_done <= 1'b0;
    mdl[5] = mdl[5] | 8'h02;
    repeat (2) @(posedge pclk);
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, conversion_done} = 5'h00;
    {paddr, pwdata} = 64'h0;
    seed = 16'h03A1;
    {gp_out, gp_oe_n} = seed[1:0];
    foreach (mdl[k]) mdl[k] = rst[k];
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (mdl[k]) rd(k);
    chk_cfg();
    for (int k = 0; k < 7; k++) begin
      seed = lfsr(seed);
      if (k != 5) wr(k, (k == 4) ? {seed[7:3], 3'h3} : seed[7:0]);
      rd(k);
    end
    chk_cfg();
    apb(1'b1, 8'h05, 32'hFF);
    `CHK(e, 1'b1)
    apb(1'b0, 8'h05, 32'h0);
    `CHK({q, e}, 33'h1)
    // Every byte count, release point alternating
    for (int n = 0; n < 8; n++) begin
      seed = lfsr(seed);
      wr(0, {7'h0, n[0]});
      wr(2, seed[7:0]);
      wr(3, n[7:0]);
      wr(6, {6'h0, seed[9:8]});
      frame_chk(n + 1);
    end
    wr(5, 8'h03);
    @(posedge pclk);
    `CHK(irq, 1'b0)
    wr(4, 8'h83);
    wr(6, 8'h02);
    pulse();
    `CHK({conversion_ready_n, gpio_pin_six_o}, 2'h0)
    `CHK({gpio_pin_six_oe_n_o, irq}, 2'h1)
    n_clr = 0;
    wr(2, 8'h1B);
    wr(3, 8'h00);
    frame_chk(1);
    `CHK(conversion_ready_n, 1'b1)
    `CHK(n_clr, 1)
    wr(4, 8'h23);
    pulse();
    frame_chk(1);
    `CHK(n_clr, 1)
    `CHK(gpio_pin_six_o, gp_out)
    `CHK(gpio_pin_six_oe_n_o, gp_oe_n)
    conclude();
  end
endmodule
bind sicr_regs sicr_regs_sva chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .cs_n(cs_n), .sdo_oe_n(sdo_oe_n),
  .conversion_done(conversion_done), .conversion_ready_n(conversion_ready_n),
  .check_clear(check_clear), .gpio_pin_six_o(gpio_pin_six_o),
  .gpio_pin_six_oe_n_o(gpio_pin_six_oe_n_o), .cfg(cfg));

// file: src/sicr_pkg.sv
// Constants and carrier types for the serial interface control registers
package sicr_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_HANDSHAKE = 8'h01;
  localparam logic [7:0] IDX_STREAM = 8'h03;
  localparam logic [7:0] IDX_RD_START = 8'h09;
  localparam logic [7:0] IDX_RD_LEN = 8'h0A;
  localparam logic [7:0] IDX_READY_CTL = 8'h11;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
  localparam int ADDR_LSB = 2;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_HANDSHAKE = 8'h00;
  localparam logic [7:0] RST_STREAM = 8'h00;
  localparam logic [6:0] RST_RD_START = 7'h1A;
  localparam logic [2:0] RST_RD_LEN = 3'h2;
  localparam logic [7:0] RST_READY_CTL = 8'h03;
  localparam int HS_RELEASE_BIT = 0;
  localparam int STREAM_KIND_BIT = 7;
  localparam int READY_PIN_BIT = 7;
  localparam int CHECK_RST_BIT = 5;
  localparam int GAIN_CAL_BIT = 3;
  localparam logic [7:0] READY_CTL_MASK = 8'hAF;

  // Address of the low byte of the conversion result
  localparam logic [6:0] RESULT_LOW_ADDR = 7'h1B;

  // ----------------------------------------------------------------
  // Interrupt status bits
  // ----------------------------------------------------------------
  localparam int IRQ_W = 2;
  localparam int IRQ_FRAME_DONE = 0;
  localparam int IRQ_READY = 1;

  // ----------------------------------------------------------------
  // Serial frame geometry
  // ----------------------------------------------------------------
  localparam int BYTE_BITS = 8;
  localparam logic [6:0] BYTE_END = 7'h07;

  // Configuration handed to the rest of the front-end
  typedef struct packed {
    logic output_release_delay_sel;
    logic stream_kind_sel;
    logic [6:0] controlled_stream_len;
    logic [6:0] direct_read_start;
    logic [2:0] direct_read_byte_count;
    logic ready_on_pin_six;
    logic check_reset_disable;
    logic fixed_gain_cal_sel;
  } sicr_cfg_s;

  // Pins of the serial link
  typedef struct packed {
    logic sclk;
    logic cs_n;
  } sicr_link_in_s;
endpackage

// file: src/sicr_regs.sv
// Serial interface control registers with data-only read engine
// How it works
// - Release bit 0 frees sdo right after the frame's last sclk rise.
// - Release bit 1 holds sdo until the sclk fall after that last rise.
// - Stream bit 7 picks normal (0, reset) or controlled (1) streaming.
// - Stream bits 6..0 hold the controlled streaming range, reset zero.
// - A seven-bit field holds the direct read start address, reset 0x1A.
// - A three-bit field holds the byte count minus one, reset 0x2.
// - Ready bit 7 puts conversion_ready_n on pin six in place of GPIO.
// - Ready bit 5 clear lets ready deassertion clear the check sum.
// - Ready bit 3 picks live gain correction or last known coefficients.
// - The ready line goes high once the result low byte has been read.
module sicr_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclk,
  input wire logic cs_n,
  output logic sdo_o,
  output logic sdo_oe_n,
  output logic [6:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic conversion_done,
  output logic conversion_ready_n,
  output logic check_clear,
  input wire logic gpio_pin_six_out,
  input wire logic gpio_pin_six_oe_n,
  output logic gpio_pin_six_o,
  output logic gpio_pin_six_oe_n_o,
  output sicr_pkg::sicr_cfg_s cfg,
  output logic irq
);
  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  // Address bits 1..0 are ignored: each register is one aligned word
  function automatic logic idx_is(input logic [31:0] a,
                                  input logic [7:0] idx);
    idx_is = (a[31:sicr_pkg::ADDR_LSB] == {22'h000000, idx});
  endfunction

  // Register storage and bus answer state
  logic handshake_r;
  logic [7:0] stream_r;
  logic [6:0] rd_start_r;
  logic [2:0] rd_len_r;
  logic [7:0] ready_ctl_r;
  logic [sicr_pkg::IRQ_W-1:0] irq_status_r;
  logic [sicr_pkg::IRQ_W-1:0] irq_mask_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [sicr_pkg::IRQ_W-1:0] irq_event;

  // Phase decode of the bus handshake
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire hit_hs = idx_is(paddr, sicr_pkg::IDX_HANDSHAKE);
  wire hit_st = idx_is(paddr, sicr_pkg::IDX_STREAM);
  wire hit_start = idx_is(paddr, sicr_pkg::IDX_RD_START);
  wire hit_len = idx_is(paddr, sicr_pkg::IDX_RD_LEN);
  wire hit_rdy = idx_is(paddr, sicr_pkg::IDX_READY_CTL);
  wire hit_ist = idx_is(paddr, sicr_pkg::IDX_IRQ_STATUS);
  wire hit_imk = idx_is(paddr, sicr_pkg::IDX_IRQ_MASK);
  wire mapped = hit_hs | hit_st | hit_start | hit_len | hit_rdy |
                hit_ist | hit_imk;

  // Unmapped indices answer with an error and read as zero
  // Read mux; reserved bits read as zero
  wire [7:0] rd_mux =
    hit_hs ? {7'h00, handshake_r} :
    hit_st ? stream_r :
    hit_start ? {1'b0, rd_start_r} :
    hit_len ? {5'h00, rd_len_r} :
    hit_rdy ? ready_ctl_r :
    hit_ist ? {6'h00, irq_status_r} :
    hit_imk ? {6'h00, irq_mask_r} : 8'h00;

  // Zero wait states: read data is captured in the setup cycle
  assign pready = access;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r && access;

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= {24'h000000, rd_mux};
      pslverr_r <= !mapped;
    end
  end

  // ----------------------------------------------------------------
  // Configuration and interrupt registers
  // ----------------------------------------------------------------
  // Setup-phase values never land; only the access edge writes
  // Configuration registers, written at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      handshake_r <= sicr_pkg::RST_HANDSHAKE[sicr_pkg::HS_RELEASE_BIT];
      stream_r <= sicr_pkg::RST_STREAM;
      rd_start_r <= sicr_pkg::RST_RD_START;
      rd_len_r <= sicr_pkg::RST_RD_LEN;
      ready_ctl_r <= sicr_pkg::RST_READY_CTL;
      irq_mask_r <= '0;
    end else if (wr) begin
      if (hit_hs)
        handshake_r <= pwdata[sicr_pkg::HS_RELEASE_BIT];
      if (hit_st)
        stream_r <= pwdata[7:0];
      if (hit_start)
        rd_start_r <= pwdata[6:0];
      if (hit_len)
        rd_len_r <= pwdata[2:0];
      // Ready control bits 6 and 4 are not stored and read as zero
      // Low bits stored as written; software keeps them at reset value
      if (hit_rdy)
        ready_ctl_r <= pwdata[7:0] & sicr_pkg::READY_CTL_MASK;
      if (hit_imk)
        irq_mask_r <= pwdata[sicr_pkg::IRQ_W-1:0];
    end
  end

  // Masking never hides a status bit from a polling read
  // Sticky status; a new event beats a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq_status_r <= '0;
    else if (wr && hit_ist)
      irq_status_r <= (irq_status_r & ~pwdata[sicr_pkg::IRQ_W-1:0]) |
                      irq_event;
    else
      irq_status_r <= irq_status_r | irq_event;
  end

  // Level interrupt while any unmasked status bit is set
  assign irq = |(irq_status_r & irq_mask_r);

  // ----------------------------------------------------------------
  // Configuration view
  // ----------------------------------------------------------------
  // Field view for the converter core
  assign cfg.output_release_delay_sel = handshake_r;
  assign cfg.stream_kind_sel =
    stream_r[sicr_pkg::STREAM_KIND_BIT];
  assign cfg.controlled_stream_len = stream_r[6:0];
  assign cfg.direct_read_start = rd_start_r;
  assign cfg.direct_read_byte_count = rd_len_r;
  assign cfg.ready_on_pin_six = ready_ctl_r[sicr_pkg::READY_PIN_BIT];
  assign cfg.check_reset_disable = ready_ctl_r[sicr_pkg::CHECK_RST_BIT];
  // Core uses this only in the matching cal and scan modes
  assign cfg.fixed_gain_cal_sel =
    ready_ctl_r[sicr_pkg::GAIN_CAL_BIT];

  // ----------------------------------------------------------------
  // Link pin synchronisers
  // ----------------------------------------------------------------
  // Both link pins travel together through the same flop chain
  sicr_pkg::sicr_link_in_s link_meta_r;
  sicr_pkg::sicr_link_in_s link_sync_r;
  sicr_pkg::sicr_link_in_s link_prev_r;

  // Two flops per pin, then a third for edge finding
  // Reset values match the idle pins, so reset makes no false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_meta_r <= '{sclk: 1'b0, cs_n: 1'b1};
      link_sync_r <= '{sclk: 1'b0, cs_n: 1'b1};
      link_prev_r <= '{sclk: 1'b0, cs_n: 1'b1};
    end else begin
      link_meta_r <= '{sclk: sclk, cs_n: cs_n};
      link_sync_r <= link_meta_r;
      link_prev_r <= link_sync_r;
    end
  end

  // Edges show a few cycles late; sclk must run far slower than pclk
  wire sclk_rise = link_sync_r.sclk && !link_prev_r.sclk;
  wire sclk_fall = !link_sync_r.sclk && link_prev_r.sclk;
  wire frame_start = !link_sync_r.cs_n && link_prev_r.cs_n;
  wire frame_stop = link_sync_r.cs_n && !link_prev_r.cs_n;

  // ----------------------------------------------------------------
  // Data-only read engine
  // ----------------------------------------------------------------
  // DONE ignores extra sclk pulses until chip select rises
  typedef enum logic [1:0] {
    SICR_IDLE,
    SICR_SHIFT,
    SICR_HOLD,
    SICR_DONE
  } sicr_state_e;

  // Engine state, address and shift data
  sicr_state_e state_r;
  sicr_state_e state_nxt;
  logic [6:0] bit_cnt_r;
  logic [6:0] addr_r;
  logic [7:0] shift_r;
  logic load_pend_r;
  logic low_byte_read;

  // Frame length in bits: (count + 1) bytes
  // At most 64 bits, which the seven-bit counter still holds
  wire [3:0] byte_total = {1'b0, rd_len_r} + 4'h1;
  wire [6:0] bit_total = {byte_total, 3'h0};
  wire [6:0] bit_cnt_inc = bit_cnt_r + 7'h01;
  wire last_rise = sclk_rise && (bit_cnt_inc == bit_total);
  wire byte_end = sclk_rise &&
                  ((bit_cnt_r & sicr_pkg::BYTE_END) == sicr_pkg::BYTE_END);

  // Outputs come straight from the state, address and shift registers
  assign rd_addr = addr_r;
  assign sdo_o = shift_r[sicr_pkg::BYTE_BITS-1];
  assign sdo_oe_n = !((state_r == SICR_SHIFT) || (state_r == SICR_HOLD));

  // Frame sequencing; chip select rising always ends the frame
  // A frame cut short still drops the drive and returns to idle
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SICR_IDLE:
        if (frame_start)
          state_nxt = SICR_SHIFT;
      SICR_SHIFT:
        if (frame_stop)
          state_nxt = SICR_IDLE;
        else if (last_rise && handshake_r)
          state_nxt = SICR_HOLD;
        else if (last_rise)
          state_nxt = SICR_DONE;
      SICR_HOLD:
        if (frame_stop)
          state_nxt = SICR_IDLE;
        else if (sclk_fall)
          state_nxt = SICR_DONE;
      SICR_DONE:
        if (frame_stop)
          state_nxt = SICR_IDLE;
    endcase
  end

  // State register, reset to idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      state_r <= SICR_IDLE;
    else
      state_r <= state_nxt;
  end

  // Shifter: bits change on falling sclk, host samples on rising
  // A load waits for sclk low so a byte never changes under a rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_r <= 7'h00;
      addr_r <= 7'h00;
      shift_r <= 8'h00;
      load_pend_r <= 1'b0;
    end else if (state_r == SICR_IDLE) begin
      bit_cnt_r <= 7'h00;
      addr_r <= rd_start_r;
      load_pend_r <= frame_start;
    end else if (state_r == SICR_SHIFT) begin
      if (load_pend_r && !link_sync_r.sclk) begin
        shift_r <= rd_data;
        load_pend_r <= 1'b0;
      end else if (sclk_fall) begin
        shift_r <= {shift_r[6:0], 1'b0};
      end
      if (sclk_rise)
        bit_cnt_r <= bit_cnt_inc;
      // Next address fetched once the current byte is out
      if (byte_end && !last_rise) begin
        addr_r <= addr_r + 7'h01;
        load_pend_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Conversion ready and check accumulator clear
  // ----------------------------------------------------------------
  // Ready line and one-shot clear, both registered
  logic ready_n_r;
  logic check_clear_r;

  assign low_byte_read = (state_r == SICR_SHIFT) && byte_end &&
                         (addr_r == sicr_pkg::RESULT_LOW_ADDR);
  // Only a real high-going ready edge clears the check sum
  wire ready_deassert = low_byte_read && !ready_n_r;

  // A fresh conversion outranks a read in the same cycle
  // A frame that skips the low byte leaves the ready line low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_n_r <= 1'b1;
      check_clear_r <= 1'b0;
    end else begin
      if (conversion_done)
        ready_n_r <= 1'b0;
      else if (low_byte_read)
        ready_n_r <= 1'b1;
      check_clear_r <= ready_deassert && !conversion_done &&
                       !ready_ctl_r[sicr_pkg::CHECK_RST_BIT];
    end
  end

  // Registered outputs of the ready logic
  assign conversion_ready_n = ready_n_r;
  assign check_clear = check_clear_r;

  // ----------------------------------------------------------------
  // Pin six routing
  // ----------------------------------------------------------------
  // Pin six is given over to the ready signal when selected
  // GPIO logic loses the pin entirely while it carries ready
  assign gpio_pin_six_o = ready_ctl_r[sicr_pkg::READY_PIN_BIT] ?
                          ready_n_r : gpio_pin_six_out;
  assign gpio_pin_six_oe_n_o = ready_ctl_r[sicr_pkg::READY_PIN_BIT] ?
                               1'b0 : gpio_pin_six_oe_n;

  // ----------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------
  // Frame done counts only frames that actually began
  assign irq_event[sicr_pkg::IRQ_FRAME_DONE] =
    (state_r != SICR_IDLE) && frame_stop;
  assign irq_event[sicr_pkg::IRQ_READY] = conversion_done && ready_n_r;
endmodule
